// File: src/ssp_defs.svh
// register map, field positions, reset values and fixed figures of the slave serial port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_ADDR_W 3
`define SSP_OFF_BAUD 3'h0
`define SSP_OFF_RXBUF 3'h1
`define SSP_OFF_RXCTL 3'h2
`define SSP_OFF_TXCTL 3'h3
`define SSP_OFF_TXDATA 3'h4
`define SSP_OFF_IRQEN 3'h5
`define SSP_OFF_FLAGS 3'h6
`define SSP_BAUD_IDLE 6
`define SSP_BAUD_CPS 4
`define SSP_RX_SERIAL_PORT_ENABLE 7
`define SSP_RX_RX9 6
`define SSP_RX_SINGLE_RECEIVE_ENABLE 5
`define SSP_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define SSP_RX_OVERRUN_ERROR 1
`define SSP_RX_NINTH_RECEIVE_BIT 0
`define SSP_TX_CLOCK_SOURCE_MASTER 7
`define SSP_TX_TX9 6
`define SSP_TX_TRANSMIT_ENABLE 5
`define SSP_TX_SYNC 4
`define SSP_TX_EMPTY 1
`define SSP_TX_NINTH_TRANSMIT_BIT 0
`define SSP_IE_GIE 7
`define SSP_IE_PERIPHERAL_IRQ_ENABLE 6
`define SSP_IE_RECEIVE_IRQ_ENABLE 5
`define SSP_IE_TRANSMIT_IRQ_ENABLE 4
`define SSP_FL_RXF 5
`define SSP_FL_TXF 4
`define SSP_CTL_RESET 8'h00
`define SSP_ISR_VECTOR 12'h004
`define SSP_LEN_8 4'h8
`define SSP_LEN_9 4'h9
`endif

// File: src/ssp_pkg.sv
// types shared by the slave serial port
package ssp_pkg;
  typedef enum logic {SSP_TX_IDLE, SSP_TX_SHIFT} ssp_tx_state_t;
endpackage : ssp_pkg

// File: src/ssp_slave.sv
// synchronous slave serial port: registers, receive fifo, transmit buffer, pin logic
//
// Notes on behaviour
// R1: slave receiver runs regardless of continuous receive
// R2: single receive enable ignored in slave mode
// R3: slave when clocked mode, no master, enabled
// R4: word received in sleep reaches data register
// R5: completed word with enable raises wake request
// R6: wake with global enable calls vector 004h
// R7: ninth received bit readable in status register
// R8: receive flag set on word completion
// R9: received low bytes come from fifo, pop on read
// R10: overrun latched until continuous receive or enable cleared
// R11: only slave shifting continues during sleep
// R12: shift registers clocked by external clock only
// R13: data read unloads; flag clears when fifo empty
// R14: master drives clock and data for reception
// R15: complete word sets receive flag, wakes processor
// R16: data write fills shifter/buffer, clears transmit flag; the code clears it only when the byte goes to the buffer
// R17: master clocks, device shifts data out on pin
// R18: after word, buffer moves to shifter, flag set
// R19: write after buffer emptied clears transmit flag
// R20: transmit wake needs both transmit and peripheral enables
// R21: write with empty shifter starts transmitting at once
// R22: transmit enable required; ninth bit is msb
// R23: lsb first, ninth bit after eight data
// R24: polarity select picks launch and sample edges
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_slave #(
  parameter int RX_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sleep_mode,
  input wire logic [`SSP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic wake_req,
  output logic isr_call,
  output logic [11:0] isr_addr
);

  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);

  // a single-entry fifo leaves no pointer bits, so refuse it at elaboration
  if (RX_DEPTH < 2)
  begin : g_depth_check
    $error("ssp_slave: RX_DEPTH must be at least 2");
  end

  typedef struct packed {
    logic cps;
    logic serial_port_enable;
    logic rx9;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic clock_source_master;
    logic tx9;
    logic transmit_enable;
    logic clocked_mode_select;
    logic ninth_transmit_bit;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic receive_irq_enable;
    logic transmit_irq_enable;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic dt_s1;
    logic dt_s2;
    logic [8:0] receive_shift_reg;
    logic [3:0] rx_cnt;
    logic overrun_error;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] fcnt;
    ssp_pkg::ssp_tx_state_t tx_state;
    logic [8:0] transmit_shift_reg;
    logic [3:0] tx_cnt;
    logic tx_sampled;
    logic [7:0] txbuf;
    logic txbuf_full;
    logic txf;
    logic [7:0] rdata;
    logic sdo;
    logic sdoe;
    logic wake;
    logic isr;
    logic [11:0] isr_addr;
  } ssp_state_t;

  ssp_state_t st;
  ssp_state_t next_st;
  logic [8:0] fifo [RX_DEPTH];
  logic push;

  function automatic logic [3:0] ssp_word_len(input logic nine);
    ssp_word_len = nine ? `SSP_LEN_9 : `SSP_LEN_8; // [R23]
  endfunction : ssp_word_len

  function automatic logic [PW-1:0] ssp_ptr_inc(input logic [PW-1:0] p);
    if (p == PW'(RX_DEPTH - 1))
    begin
      ssp_ptr_inc = '0;
    end
    else
    begin
      ssp_ptr_inc = p + PW'(1);
    end
  endfunction : ssp_ptr_inc

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    logic slave;
    logic rise;
    logic fall;
    logic launch;
    logic sample;
    logic rx_on;
    logic pop;
    logic [3:0] rx_len;
    logic [3:0] tx_len;
    logic tx_done;
    logic [8:0] rx_word;
    slave = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    launch = 1'b0;
    sample = 1'b0;
    rx_on = 1'b0;
    pop = 1'b0;
    rx_len = 4'h0;
    tx_len = 4'h0;
    tx_done = 1'b0;
    rx_word = 9'h000;
    push = 1'b0;
    next_st = st;

    next_st.ck_s1 = serial_clock_pin;
    next_st.ck_s2 = st.ck_s1;
    next_st.ck_d = st.ck_s2;
    next_st.dt_s1 = serial_data_in;
    next_st.dt_s2 = st.dt_s1;

    // sleep_mode needs no gating: all shifting here follows the pin clock
    slave = st.clocked_mode_select & ~st.clock_source_master & st.serial_port_enable; // [R3] [R11]
    rise = st.ck_s2 & ~st.ck_d; // [R12]
    fall = ~st.ck_s2 & st.ck_d;
    launch = st.cps ? rise : fall; // [R24]
    sample = st.cps ? fall : rise; // [R24]
    // the pin is half duplex, so in slave mode the receiver listens whenever we do not drive
    rx_on = slave & ~st.transmit_enable; // [R1] [R2] [R14]
    rx_len = ssp_word_len(st.rx9);
    tx_len = ssp_word_len(st.tx9);

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `SSP_OFF_BAUD:
        begin
          next_st.cps = reg_wdata[`SSP_BAUD_CPS];
        end
        `SSP_OFF_RXCTL:
        begin
          next_st.serial_port_enable = reg_wdata[`SSP_RX_SERIAL_PORT_ENABLE];
          next_st.rx9 = reg_wdata[`SSP_RX_RX9];
          next_st.single_receive_enable = reg_wdata[`SSP_RX_SINGLE_RECEIVE_ENABLE];
          next_st.continuous_receive_enable = reg_wdata[`SSP_RX_CONTINUOUS_RECEIVE_ENABLE];
        end
        `SSP_OFF_TXCTL:
        begin
          next_st.clock_source_master = reg_wdata[`SSP_TX_CLOCK_SOURCE_MASTER];
          next_st.tx9 = reg_wdata[`SSP_TX_TX9];
          next_st.transmit_enable = reg_wdata[`SSP_TX_TRANSMIT_ENABLE];
          next_st.clocked_mode_select = reg_wdata[`SSP_TX_SYNC];
          next_st.ninth_transmit_bit = reg_wdata[`SSP_TX_NINTH_TRANSMIT_BIT];
        end
        `SSP_OFF_IRQEN:
        begin
          next_st.global_irq_enable = reg_wdata[`SSP_IE_GIE];
          next_st.peripheral_irq_enable = reg_wdata[`SSP_IE_PERIPHERAL_IRQ_ENABLE];
          next_st.receive_irq_enable = reg_wdata[`SSP_IE_RECEIVE_IRQ_ENABLE];
          next_st.transmit_irq_enable = reg_wdata[`SSP_IE_TRANSMIT_IRQ_ENABLE];
        end
        default:
        begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads, answered one cycle later
    next_st.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `SSP_OFF_BAUD:
        begin
          next_st.rdata[`SSP_BAUD_CPS] = st.cps;
          next_st.rdata[`SSP_BAUD_IDLE] = (st.rx_cnt == 4'h0);
        end
        `SSP_OFF_RXBUF:
        begin
          next_st.rdata = fifo[st.rd_ptr][7:0]; // [R9]
          pop = (st.fcnt != '0); // [R13]
        end
        `SSP_OFF_RXCTL:
        begin
          next_st.rdata[`SSP_RX_SERIAL_PORT_ENABLE] = st.serial_port_enable;
          next_st.rdata[`SSP_RX_RX9] = st.rx9;
          next_st.rdata[`SSP_RX_SINGLE_RECEIVE_ENABLE] = st.single_receive_enable;
          next_st.rdata[`SSP_RX_CONTINUOUS_RECEIVE_ENABLE] = st.continuous_receive_enable;
          next_st.rdata[`SSP_RX_OVERRUN_ERROR] = st.overrun_error;
          next_st.rdata[`SSP_RX_NINTH_RECEIVE_BIT] = fifo[st.rd_ptr][8]; // [R7]
        end
        `SSP_OFF_TXCTL:
        begin
          next_st.rdata[`SSP_TX_CLOCK_SOURCE_MASTER] = st.clock_source_master;
          next_st.rdata[`SSP_TX_TX9] = st.tx9;
          next_st.rdata[`SSP_TX_TRANSMIT_ENABLE] = st.transmit_enable;
          next_st.rdata[`SSP_TX_SYNC] = st.clocked_mode_select;
          next_st.rdata[`SSP_TX_EMPTY] = (st.tx_state == ssp_pkg::SSP_TX_IDLE);
          next_st.rdata[`SSP_TX_NINTH_TRANSMIT_BIT] = st.ninth_transmit_bit;
        end
        `SSP_OFF_IRQEN:
        begin
          next_st.rdata[`SSP_IE_GIE] = st.global_irq_enable;
          next_st.rdata[`SSP_IE_PERIPHERAL_IRQ_ENABLE] = st.peripheral_irq_enable;
          next_st.rdata[`SSP_IE_RECEIVE_IRQ_ENABLE] = st.receive_irq_enable;
          next_st.rdata[`SSP_IE_TRANSMIT_IRQ_ENABLE] = st.transmit_irq_enable;
        end
        `SSP_OFF_FLAGS:
        begin
          next_st.rdata[`SSP_FL_RXF] = (st.fcnt != '0);
          next_st.rdata[`SSP_FL_TXF] = st.txf;
        end
        default:
        begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver
    rx_word = {st.dt_s2, st.receive_shift_reg[8:1]}; // [R23]
    if (rx_on & sample)
    begin
      if (st.rx_cnt + 4'h1 == rx_len)
      begin
        next_st.rx_cnt = 4'h0;
        next_st.receive_shift_reg = 9'h000;
        // an 8-bit word sits one place high after eight right shifts
        if (!st.rx9)
        begin
          rx_word = {1'b0, rx_word[8:1]};
        end
        if (st.overrun_error || (st.fcnt == CW'(RX_DEPTH) && !pop))
        begin
          next_st.overrun_error = 1'b1; // [R10]
        end
        else
        begin
          push = 1'b1; // [R4] [R8] [R15]
        end
      end
      else
      begin
        next_st.rx_cnt = st.rx_cnt + 4'h1;
        next_st.receive_shift_reg = rx_word;
      end
    end
    if (!st.continuous_receive_enable)
    begin
      next_st.overrun_error = 1'b0; // [R10]
    end
    if (push)
    begin
      next_st.wr_ptr = ssp_ptr_inc(st.wr_ptr);
    end
    if (pop)
    begin
      next_st.rd_ptr = ssp_ptr_inc(st.rd_ptr); // [R13]
    end
    next_st.fcnt = st.fcnt + CW'(push) - CW'(pop);

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    case (st.tx_state)
      ssp_pkg::SSP_TX_IDLE:
      begin
        next_st.sdo = 1'b1;
      end
      ssp_pkg::SSP_TX_SHIFT:
      begin
        next_st.sdo = st.transmit_shift_reg[0]; // [R17] [R23]
        if (sample)
        begin
          next_st.tx_cnt = st.tx_cnt + 4'h1;
          next_st.tx_sampled = 1'b1;
        end
        if (launch && st.tx_sampled)
        begin
          next_st.tx_sampled = 1'b0;
          next_st.transmit_shift_reg = {1'b1, st.transmit_shift_reg[8:1]};
          if (st.tx_cnt == tx_len)
          begin
            tx_done = 1'b1;
            next_st.tx_state = ssp_pkg::SSP_TX_IDLE;
          end
        end
      end
      default:
      begin
        next_st.tx_state = ssp_pkg::SSP_TX_IDLE;
      end
    endcase

    if (tx_done && st.txbuf_full && st.transmit_enable)
    begin
      // buffered byte follows straight on; flag rises as buffer empties
      next_st.transmit_shift_reg = {st.ninth_transmit_bit, st.txbuf}; // [R18] [R22]
      next_st.tx_cnt = 4'h0;
      next_st.tx_state = ssp_pkg::SSP_TX_SHIFT;
      next_st.txbuf_full = 1'b0;
      next_st.txf = 1'b1; // [R18]
    end

    // a held byte moves first, so a write in the same cycle refills the buffer instead of being lost
    if (st.tx_state == ssp_pkg::SSP_TX_IDLE && st.txbuf_full && st.transmit_enable && slave)
    begin
      next_st.transmit_shift_reg = {st.ninth_transmit_bit, st.txbuf}; // [R21]
      next_st.tx_cnt = 4'h0;
      next_st.tx_sampled = 1'b0;
      next_st.tx_state = ssp_pkg::SSP_TX_SHIFT;
      next_st.txbuf_full = 1'b0;
      next_st.txf = 1'b1;
    end

    if (reg_wr && reg_addr == `SSP_OFF_TXDATA)
    begin
      if (next_st.tx_state == ssp_pkg::SSP_TX_IDLE && st.transmit_enable && slave && !next_st.txbuf_full)
      begin
        next_st.transmit_shift_reg = {st.ninth_transmit_bit, reg_wdata}; // [R21] [R22]
        next_st.tx_cnt = 4'h0;
        next_st.tx_sampled = 1'b0;
        next_st.tx_state = ssp_pkg::SSP_TX_SHIFT;
        next_st.sdo = reg_wdata[0];
      end
      else
      begin
        next_st.txbuf = reg_wdata; // [R16]
        next_st.txbuf_full = 1'b1;
        next_st.txf = 1'b0; // [R16] [R19]
      end
    end

    if (!st.transmit_enable)
    begin
      next_st.tx_state = ssp_pkg::SSP_TX_IDLE; // [R22]
      next_st.tx_cnt = 4'h0;
      next_st.tx_sampled = 1'b0;
    end
    next_st.sdoe = slave & st.transmit_enable; // [R17] [R22]

    ////////////////////////////////////////////////////////////////////////////
    // clearing the enable resets the whole port but keeps its settings
    if (!st.serial_port_enable)
    begin
      next_st.receive_shift_reg = 9'h000; // [R10]
      next_st.rx_cnt = 4'h0;
      next_st.overrun_error = 1'b0;
      next_st.wr_ptr = '0;
      next_st.rd_ptr = '0;
      next_st.fcnt = '0;
      next_st.tx_state = ssp_pkg::SSP_TX_IDLE;
      next_st.transmit_shift_reg = 9'h1ff;
      next_st.tx_cnt = 4'h0;
      next_st.tx_sampled = 1'b0;
      next_st.txbuf_full = 1'b0;
      next_st.txf = 1'b1;
      next_st.sdo = 1'b1;
      push = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake and vector requests
    next_st.wake = (st.fcnt != '0 && st.receive_irq_enable) // [R5] [R15]
                 | (st.txf && st.transmit_irq_enable && st.peripheral_irq_enable); // [R20]
    next_st.isr = st.wake & st.global_irq_enable; // [R6]
    next_st.isr_addr = `SSP_ISR_VECTOR; // [R6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.transmit_shift_reg <= 9'h1ff;
      st.txf <= 1'b1;
      st.sdo <= 1'b1;
      st.isr_addr <= `SSP_ISR_VECTOR;
      st.tx_state <= ssp_pkg::SSP_TX_IDLE;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // the fifo array has no reset: the count says which words are valid
  always_ff @(posedge core_clk)
  begin
    if (clk_en && push)
    begin
      fifo[st.wr_ptr] <= st.rx9 ? {st.dt_s2, st.receive_shift_reg[8:1]} : {1'b0, st.dt_s2, st.receive_shift_reg[8:2]}; // [R9]
    end
  end

  assign reg_rdata = st.rdata;
  assign serial_data_out = st.sdo;
  assign serial_data_oe = st.sdoe;
  assign wake_req = st.wake;
  assign isr_call = st.isr;
  assign isr_addr = st.isr_addr;

endmodule : ssp_slave

// File: tb/ssp_slave_monitor.sv
// port-level assertion checker for the slave serial port
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_slave_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sleep_mode,
  input wire logic [`SSP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic wake_req,
  input wire logic isr_call,
  input wire logic [11:0] isr_addr
);
  // cycles since the last write or pin clock change, saturating
  logic [3:0] quiet;
  logic [1:0] wr_age;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      quiet <= 4'h0;
      wr_age <= 2'h0;
    end
    else
    begin
      quiet <= (reg_wr || serial_clock_pin != $past(serial_clock_pin)) ? 4'h0 : quiet + 4'(quiet != 4'hf);
      wr_age <= reg_wr ? 2'h0 : wr_age + 2'(wr_age != 2'h3);
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_vector_fixed: assert property (isr_addr == `SSP_ISR_VECTOR)
    else $error("isr address moved");
  a_isr_after_wake: assert property (isr_call |-> $past(wake_req))
    else $error("isr call without wake");
  a_wake_cause: assert property ($rose(wake_req) |-> quiet < 4'd10)
    else $error("wake rose without cause");
  a_wake_drop: assert property ($fell(wake_req) |-> $past(reg_rd, 2) || $past(reg_rd, 3) || wr_age < 2'd3)
    else $error("wake fell without access");
  // launches come only from pin clock edges or a register write
  a_line_quiet: assert property (quiet > 4'd7 |=> $stable(serial_data_out))
    else $error("data out moved while link idle");
  a_drive_by_write: assert property ($changed(serial_data_oe) |-> wr_age < 2'd3)
    else $error("output enable moved without write");
  a_read_stands: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 3'h7 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : ssp_slave_monitor

bind ssp_slave ssp_slave_monitor u_ssp_slave_monitor (.core_clk, .sys_rst, .clk_en, .sleep_mode, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_clock_pin, .serial_data_in, .serial_data_out,
  .serial_data_oe, .wake_req, .isr_call, .isr_addr);

// File: tb/ssp_master_model.sv
// external synchronous master: clocks frames in and out of the slave port
`timescale 1ns/1ps
module ssp_master_model (
  output logic sck,
  output logic sdat,
  input wire logic pin
);
  initial
  begin
    sck = 1'b0;
    sdat = 1'b1;
  end
  // clock stands at its idle level between frames; first toggle is the sampling edge
  task automatic frame(input logic cps, input logic [3:0] n, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h000;
    sck = cps;
    #800;
    for (int i = 0; i < n; i++)
    begin
      sdat = tx[i];
      #400 sck = ~sck;
      #400 rx[i] = pin;
      sck = ~sck;
    end
    // hold time over: line no longer shows the last bit
    #400 sdat = ~sdat;
  endtask : frame
endmodule : ssp_master_model

// File: tb/tb.sv
// self-checking bench for the slave serial port
`timescale 1ns/1ps
`include "ssp_defs.svh"
module tb;
  typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] m; logic [7:0] e;} ssp_row_t;
  localparam ssp_row_t rows [6] = '{'{`SSP_OFF_IRQEN, 8'hf0, 8'hff, 8'hf0}, '{`SSP_OFF_IRQEN, 8'h00, 8'hff, 8'h00},
    '{`SSP_OFF_BAUD, 8'h10, 8'h50, 8'h50}, '{`SSP_OFF_TXCTL, 8'hf1, 8'hff, 8'hf3},
    '{`SSP_OFF_TXCTL, 8'h00, 8'hff, 8'h02}, '{3'h7, 8'hff, 8'hff, 8'h00}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sleep_mode = 1'b0;
  logic [`SSP_ADDR_W-1:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic serial_clock_pin;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_oe;
  logic wake_req;
  logic isr_call;
  logic [11:0] isr_addr;
  logic m_dat;
  logic [7:0] v;
  logic [8:0] d;
  logic [8:0] rx;
  int mismatches = 0;
  int checks = 0;
  // shared data wire: the slave wins while it drives
  assign serial_data_in = serial_data_oe ? serial_data_out : m_dat;
  always #50 core_clk = ~core_clk;
  ssp_slave u_ssp_slave (.core_clk, .sys_rst, .clk_en, .sleep_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .serial_clock_pin, .serial_data_in, .serial_data_out, .serial_data_oe, .wake_req, .isr_call,
    .isr_addr);
  ssp_master_model u_ssp_master_model (.sck(serial_clock_pin), .sdat(m_dat), .pin(serial_data_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #5000000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`SSP_OFF_FLAGS, v);
    chk(v, 8'h10);
    chk({serial_data_oe, serial_data_out, wake_req, isr_call}, 4'h4);
    chk(isr_addr, `SSP_ISR_VECTOR);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk(v & rows[i].m, rows[i].e);
    end
    // reception in sleep, both polarities, 8 and 9 bits, single receive on and continuous off
    sleep_mode <= 1'b1;
    wr(`SSP_OFF_TXCTL, 8'h10);
    wr(`SSP_OFF_IRQEN, 8'ha0);
    for (int i = 0; i < 4; i++)
    begin
      d = 9'h1a5 ^ 9'(i * 9'h06b);
      wr(`SSP_OFF_BAUD, {3'h0, i[0] ^ i[1], 4'h0});
      wr(`SSP_OFF_RXCTL, {1'b1, i[1], 6'h20});
      u_ssp_master_model.frame(i[0] ^ i[1], 4'h8 + 4'(i[1]), d, rx);
      rd(`SSP_OFF_FLAGS, v);
      chk(v, 8'h30);
      chk({wake_req, isr_call}, 2'h3);
      rd(`SSP_OFF_RXCTL, v);
      chk(v & {7'h7f, i[1]}, {1'b1, i[1], 6'h20} | 8'(i[1] & d[8]));
      rd(`SSP_OFF_RXBUF, v);
      chk(v, d[7:0]);
      rd(`SSP_OFF_FLAGS, v);
      chk({v, wake_req}, 9'h020);
    end
    // overrun with a depth of two, cleared once by continuous receive and once by port enable
    for (int j = 0; j < 2; j++)
    begin
      wr(`SSP_OFF_RXCTL, 8'h90);
      for (int k = 1; k < 4; k++)
        u_ssp_master_model.frame(1'b0, 4'h8, 9'(k * 9'h011), rx);
      rd(`SSP_OFF_RXCTL, v);
      chk(v & 8'hfe, 8'h92);
      wr(`SSP_OFF_RXCTL, j ? 8'h10 : 8'h80);
      rd(`SSP_OFF_RXCTL, v);
      chk(v & 8'hfe, j ? 8'h10 : 8'h80);
      rd(`SSP_OFF_FLAGS, v);
      chk(v, j ? 8'h10 : 8'h30);
      for (int k = 1; k < 3 - j * 2; k++)
      begin
        rd(`SSP_OFF_RXBUF, v);
        chk(v, 8'(k * 8'h11));
      end
    end
    // transmit: one word straight to the shifter, one held in the buffer
    wr(`SSP_OFF_RXCTL, 8'h80);
    wr(`SSP_OFF_IRQEN, 8'h50);
    wr(`SSP_OFF_TXCTL, 8'h71);
    wr(`SSP_OFF_TXDATA, 8'h5a);
    rd(`SSP_OFF_FLAGS, v);
    chk({v, serial_data_oe, serial_data_out}, 10'h042);
    wr(`SSP_OFF_TXDATA, 8'hc3);
    rd(`SSP_OFF_FLAGS, v);
    chk({v, wake_req}, 9'h000);
    u_ssp_master_model.frame(1'b0, 4'h9, 9'h000, rx);
    chk(rx, 9'h15a);
    rd(`SSP_OFF_FLAGS, v);
    chk({v, wake_req, isr_call}, 10'h042);
    wr(`SSP_OFF_BAUD, 8'h10);
    u_ssp_master_model.frame(1'b1, 4'h9, 9'h000, rx);
    chk(rx, 9'h1c3);
    wr(`SSP_OFF_IRQEN, 8'h10);
    repeat (3) @(posedge core_clk);
    chk(wake_req, 1'b0);
    // frozen clock enable: this write must not land, so the wake stays off
    clk_en <= 1'b0;
    wr(`SSP_OFF_IRQEN, 8'hf0);
    clk_en <= 1'b1;
    rd(`SSP_OFF_IRQEN, v);
    chk({v, wake_req}, 9'h020);
    // reset in mid-transfer: one word shifting, one held in the buffer
    wr(`SSP_OFF_TXDATA, 8'h96);
    wr(`SSP_OFF_TXDATA, 8'h3c);
    rd(`SSP_OFF_TXCTL, v);
    chk({v, serial_data_oe, serial_data_out}, 10'h1c6);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`SSP_OFF_FLAGS, v);
    chk(v, 8'h10);
    rd(`SSP_OFF_TXCTL, v);
    chk({v, serial_data_oe, serial_data_out, wake_req, isr_call}, 12'h024);
    wrap_up();
  end
endmodule : tb
